// file: core/mcd_pkg.sv
// package of constants for the two-channel missing clock detector
// assumes a single 25 MHz core clock; imported whole by every design file
package mcd_pkg;

   // ----------------------------------------------------------------
   // register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CLOCK_ERROR_CONTROL = 8'h21;
   localparam logic [7:0] ADDR_CLOCK_ERROR_TIMEOUT = 8'h22;
   localparam logic [7:0] RST_CLOCK_ERROR_CONTROL = 8'h03;
   localparam logic [7:0] RST_CLOCK_ERROR_TIMEOUT = 8'h3F;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RELOAD_BIT = 7;
   localparam int DET1_SRC_BIT = 4;
   localparam int DET2_SRC_LSB = 2;
   localparam int DET1_EN_BIT = 1;
   localparam int DET2_EN_BIT = 0;
   localparam int DET1_TIME_LSB = 3;
   localparam int DET2_TIME_LSB = 0;
   localparam int TIME_CODES = 8;

   // detector two source choices, last one reserved
   typedef enum logic [1:0] {SRC2_DAC_MOD, SRC2_ADC_MOD, SRC2_PLL, SRC2_RESERVED} det2_src_t;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CORE_CLK_KHZ = 25000;
   localparam int CNT_W = 25;
   typedef logic [CNT_W-1:0] cnt_t;
   typedef int unsigned time_us_t [TIME_CODES];
   typedef cnt_t cyc_tbl_t [TIME_CODES];

   // missing-clock times in microseconds, by timeout code
   localparam time_us_t TIMEOUT_US = '{11000, 22000, 44000, 87000,
                                       174000, 350000, 700000, 1200000};

   // every time converts to whole cycles exactly; the longest fits in CNT_W bits
   function automatic cyc_tbl_t us_to_cycles(input time_us_t us);
      cyc_tbl_t t;
      for (int i = 0; i < TIME_CODES; i++) begin
         t[i] = cnt_t'((64'(us[i]) * CORE_CLK_KHZ) / 1000);
      end
      return t;
   endfunction : us_to_cycles

   localparam cyc_tbl_t DEFAULT_TIMEOUT_CYC = us_to_cycles(TIMEOUT_US);

endpackage : mcd_pkg

// file: core/det_if.sv
// carrier between the top and one detector channel
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface det_if;
   import mcd_pkg::*;
   logic enable;    // channel armed
   cnt_t limit;     // timeout in core cycles
   logic clk_level; // synchronised monitored clock
   logic expired;   // one-cycle timeout pulse

   modport detector(input enable, input limit, input clk_level, output expired);
   modport control(output enable, output limit, output clk_level, input expired);
endinterface : det_if

// file: core/clock_detector.sv
// one missing-clock channel: counts core cycles since the last edge
// assumes clk_level is already synchronised to core_clk
`timescale 1ns/1ps
module clock_detector
   import mcd_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   det_if.detector port
);

   cnt_t cnt_q, cnt_d;
   logic prev_q, prev_d;
   logic fired_q, fired_d;
   logic expired_q, expired_d;
   logic edge_seen;

   // ----------------------------------------------------------------
   // counter and edge detection
   // ----------------------------------------------------------------
   always_comb begin
      edge_seen = port.clk_level ^ prev_q;
      prev_d = port.clk_level;
      cnt_d = cnt_q;
      fired_d = fired_q;
      expired_d = 1'b0;
      if (!port.enable || edge_seen) begin
         cnt_d = '0;
         fired_d = 1'b0;
      end else begin
         if (cnt_q < port.limit) begin
            cnt_d = cnt_q + cnt_t'(1);
         end
         // fire once when the gap reaches the limit, also after a shortened limit
         if (!fired_q && (cnt_q + cnt_t'(1) >= port.limit)) begin
            expired_d = 1'b1;
            fired_d = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         prev_q <= 1'b0;
         fired_q <= 1'b0;
         expired_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         prev_q <= prev_d;
         fired_q <= fired_d;
         expired_q <= expired_d;
      end
   end

   assign port.expired = expired_q;

endmodule : clock_detector

// file: core/missing_clock_detector.sv
// two missing-clock detectors with their control registers and fault flag
// assumes monitored clocks are asynchronous pins slower than core_clk / 2,
// and register strobes are one-cycle pulses on core_clk;
// register reset values arm both detectors at the longest timeout;
// clear, restart and other-fault strobes come from logic on core_clk
//
// Functional notes
// - reload bit decides if DSP memory reloads defaults after fault restart.
// - detector one watches audio port clock at 0, PDM port clock at 1.
// - detector two source: 0 DAC modulator, 1 ADC modulator, 2 PLL, 3 reserved.
// - bit 1 enables detector one, bit 0 enables detector two.
// - enabled detector whose clock stays absent past timeout shuts device down.
// - clock error sets the flag; host clears it before powering up again.
// - detector one timeout code 0..7 gives 11 ms up to 1.2 s.
// - detector two timeout uses the same eight-step encoding.
`timescale 1ns/1ps
module missing_clock_detector
   import mcd_pkg::*;
#(
   parameter cyc_tbl_t TIMEOUT_CYC = DEFAULT_TIMEOUT_CYC
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   input wire logic audio_port_clock,
   input wire logic pdm_port_clock,
   input wire logic dac_mod_clock,
   input wire logic adc_mod_clock,
   input wire logic pll_clock,
   input wire logic clock_error_clear,
   input wire logic other_fault,
   input wire logic power_up_req,
   output logic clock_error_flag,
   output logic fault_shutdown,
   output logic dsp_reload_on_fault,
   output logic dsp_reload_defaults
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // control and timeout bytes, plus the registered read data
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] tmo_q, tmo_d;
   logic [7:0] rdata_q, rdata_d;

   // writes store whole bytes; reserved bits read back as written
   always_comb begin
      ctrl_d = ctrl_q;
      tmo_d = tmo_q;
      rdata_d = rdata_q;
      if (reg_wr_en && reg_addr == ADDR_CLOCK_ERROR_CONTROL) begin
         ctrl_d = reg_wdata;
      end
      if (reg_wr_en && reg_addr == ADDR_CLOCK_ERROR_TIMEOUT) begin
         tmo_d = reg_wdata;
      end
      if (reg_rd_en) begin
         case (reg_addr)
            ADDR_CLOCK_ERROR_CONTROL: rdata_d = ctrl_q;
            ADDR_CLOCK_ERROR_TIMEOUT: rdata_d = tmo_q;
            default: rdata_d = READ_UNMAPPED;
         endcase
      end
   end

   // register file state
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= RST_CLOCK_ERROR_CONTROL;
         tmo_q <= RST_CLOCK_ERROR_TIMEOUT;
         rdata_q <= READ_UNMAPPED;
      end else begin
         ctrl_q <= ctrl_d;
         tmo_q <= tmo_d;
         rdata_q <= rdata_d;
      end
   end

   // read data holds until the next read strobe
   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------------
   // synchronisers for the five monitored clocks
   // ----------------------------------------------------------------
   // bit order from bit 0 up: audio, pdm, dac, adc, pll
   logic [4:0] clk_raw;
   logic [4:0] meta_q, meta_d;
   logic [4:0] sync_q, sync_d;

   // gather the pins into one vector for a shared two-flop stage
   assign clk_raw = {pll_clock, adc_mod_clock, dac_mod_clock, pdm_port_clock, audio_port_clock};

   // first stage feeds only the second stage
   always_comb begin
      meta_d = clk_raw;
      sync_d = meta_q;
   end

   // synchroniser flip-flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   // ----------------------------------------------------------------
   // source selection and timeout lookup
   // ----------------------------------------------------------------
   // one carrier per detector channel
   det_if det1 ();
   det_if det2 ();
   det2_src_t src2;
   logic src2_valid;

   // detector two source field as a typed select
   assign src2 = det2_src_t'(ctrl_q[DET2_SRC_LSB +: 2]);

   // detector one inputs
   always_comb begin
      det1.enable = ctrl_q[DET1_EN_BIT];
      det1.limit = TIMEOUT_CYC[tmo_q[DET1_TIME_LSB +: 3]];
      det1.clk_level = ctrl_q[DET1_SRC_BIT] ? sync_q[1] : sync_q[0];
   end

   // detector two inputs; the reserved source keeps the channel idle
   always_comb begin
      src2_valid = 1'b1;
      case (src2)
         SRC2_DAC_MOD: det2.clk_level = sync_q[2];
         SRC2_ADC_MOD: det2.clk_level = sync_q[3];
         SRC2_PLL: det2.clk_level = sync_q[4];
         default: begin
            det2.clk_level = 1'b0;
            src2_valid = 1'b0;
         end
      endcase
      det2.enable = ctrl_q[DET2_EN_BIT] && src2_valid;
      det2.limit = TIMEOUT_CYC[tmo_q[DET2_TIME_LSB +: 3]];
   end

   // channel one: audio or pdm port clock
   clock_detector u_det1 (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .port(det1.detector)
   );

   // channel two: modulator or pll clock
   clock_detector u_det2 (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .port(det2.detector)
   );

   // ----------------------------------------------------------------
   // fault flag, shutdown and restart policy
   // ----------------------------------------------------------------
   // sticky flag, shutdown, pending fault restart and reload pulse
   logic flag_q, flag_d;
   logic shut_q, shut_d;
   logic pending_q, pending_d;
   logic reload_q, reload_d;
   logic clk_fault;
   logic power_up_ok;

   // any expiry is a clock fault; restart needs a clear flag and no new expiry
   assign clk_fault = det1.expired || det2.expired;
   assign power_up_ok = power_up_req && !flag_q && !clk_fault;

   // a new error wins over a clear in the same cycle
   always_comb begin
      flag_d = flag_q;
      shut_d = shut_q;
      pending_d = pending_q;
      reload_d = 1'b0;
      if (clock_error_clear) begin
         flag_d = 1'b0;
      end
      if (power_up_ok) begin
         shut_d = 1'b0;
         pending_d = 1'b0;
         reload_d = pending_q && ctrl_q[RELOAD_BIT];
      end
      if (other_fault) begin
         pending_d = 1'b1;
      end
      if (clk_fault) begin
         flag_d = 1'b1;
         shut_d = 1'b1;
         pending_d = 1'b1;
      end
   end

   // fault and restart state
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
         shut_q <= 1'b0;
         pending_q <= 1'b0;
         reload_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         shut_q <= shut_d;
         pending_q <= pending_d;
         reload_q <= reload_d;
      end
   end

   // outputs straight from flip-flops
   assign clock_error_flag = flag_q;
   assign fault_shutdown = shut_q;
   assign dsp_reload_on_fault = ctrl_q[RELOAD_BIT];
   assign dsp_reload_defaults = reload_q;

endmodule : missing_clock_detector

// file: dv/mcd_props.sv
// checker for the missing clock detector top ports
// assumes one core_clk domain and an active-low asynchronous reset_n
`timescale 1ns/1ps
module mcd_props
   import mcd_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata,
   input wire logic clock_error_clear,
   input wire logic power_up_req,
   input wire logic clock_error_flag,
   input wire logic fault_shutdown,
   input wire logic dsp_reload_on_fault,
   input wire logic dsp_reload_defaults
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------
   // fault flag, shutdown and restart
   // ----------------------------------------------------------------
   chk_flag_brings_shutdown: assert property ($rose(clock_error_flag) |-> fault_shutdown)
      else $error("flag rose without shutdown");
   chk_flag_sticky: assert property (clock_error_flag && !clock_error_clear |=> clock_error_flag)
      else $error("flag dropped without clear");
   chk_shutdown_holds: assert property (fault_shutdown && !power_up_req |=> fault_shutdown)
      else $error("shutdown dropped without power up");
   chk_powerup_refused: assert property (power_up_req && clock_error_flag |=> $stable(fault_shutdown))
      else $error("power up taken while flag set");
   chk_powerup_taken: assert property (power_up_req && !clock_error_flag |=> !fault_shutdown || clock_error_flag)
      else $error("power up not taken");
   // reload policy: one pulse, only on a taken restart with the policy bit set
   chk_reload_policy: assert property (dsp_reload_defaults |-> $past(power_up_req) && $past(dsp_reload_on_fault))
      else $error("reload without policy bit");
   chk_reload_single: assert property (dsp_reload_defaults |=> !dsp_reload_defaults)
      else $error("reload pulse too long");
   chk_reload_bit_write: assert property (reg_wr_en && reg_addr == ADDR_CLOCK_ERROR_CONTROL |=> dsp_reload_on_fault == $past(reg_wdata[7]))
      else $error("policy bit not written");
   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   chk_unmapped_zero: assert property (reg_rd_en && reg_addr != ADDR_CLOCK_ERROR_CONTROL && reg_addr != ADDR_CLOCK_ERROR_TIMEOUT |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_stands: assert property (!reg_rd_en |=> $stable(reg_rdata))
      else $error("read data moved without read");
   cov_fault: cover property ($rose(clock_error_flag));
   cov_reload: cover property (dsp_reload_defaults);
   cov_refused: cover property (power_up_req && clock_error_flag);
endmodule : mcd_props

bind missing_clock_detector mcd_props i_props (.core_clk(core_clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
   .reg_rdata(reg_rdata), .clock_error_clear(clock_error_clear), .power_up_req(power_up_req),
   .clock_error_flag(clock_error_flag), .fault_shutdown(fault_shutdown),
   .dsp_reload_on_fault(dsp_reload_on_fault), .dsp_reload_defaults(dsp_reload_defaults));

// file: dv/tb.sv
// self-checking bench for the missing clock detector
// assumes short timeouts through TIMEOUT_CYC; monitored clocks toggle every 4 cycles
`timescale 1ns/1ps
module tb;
   import mcd_pkg::*;
   localparam cyc_tbl_t TCYC = '{20, 40, 60, 80, 100, 120, 140, 160};
   logic core_clk = 0, reset_n = 0, reg_wr_en = 0, reg_rd_en = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [4:0] mclk = 5'h00, run = 5'h1F;
   logic clock_error_clear = 0, other_fault = 0, power_up_req = 0;
   logic clock_error_flag, fault_shutdown, dsp_reload_on_fault, dsp_reload_defaults;
   int fail_count = 0, comparisons = 0, cycles = 0, ph = 0;
   always #20 core_clk = ~core_clk;
   missing_clock_detector #(.TIMEOUT_CYC(TCYC)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata), .audio_port_clock(mclk[0]), .pdm_port_clock(mclk[1]),
      .dac_mod_clock(mclk[2]), .adc_mod_clock(mclk[3]), .pll_clock(mclk[4]),
      .clock_error_clear(clock_error_clear), .other_fault(other_fault),
      .power_up_req(power_up_req), .clock_error_flag(clock_error_flag),
      .fault_shutdown(fault_shutdown), .dsp_reload_on_fault(dsp_reload_on_fault),
      .dsp_reload_defaults(dsp_reload_defaults));
   // ----------------------------------------------------------------
   // monitored clocks and watchdog
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      #1;
      ph++;
      if (ph % 4 == 0) mclk = mclk ^ run;
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tick();
      @(posedge core_clk) #1;
   endtask : tick
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1;
      tick();
      reg_wr_en = 0;
      tick();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd_en = 1;
      tick();
      reg_rd_en = 0;
      tick();
      chk("rdata", reg_rdata, e);
   endtask : rd
   // reset values, readback, unmapped write and read
   task automatic regs_case();
      chk("reset flag", 8'(clock_error_flag), 8'h00);
      chk("reset shutdown", 8'(fault_shutdown), 8'h00);
      chk("reset reload", 8'(dsp_reload_defaults), 8'h00);
      rd(ADDR_CLOCK_ERROR_CONTROL, 8'h03);
      rd(ADDR_CLOCK_ERROR_TIMEOUT, 8'h3F);
      rd(8'h23, 8'h00);
      wr(ADDR_CLOCK_ERROR_CONTROL, 8'hA5);
      wr(8'h20, 8'hFF);
      rd(ADDR_CLOCK_ERROR_TIMEOUT, 8'h3F);
      rd(ADDR_CLOCK_ERROR_CONTROL, 8'hA5);
      chk("policy", 8'(dsp_reload_on_fault), 8'h01);
   endtask : regs_case
   // stop one clock, expect a fault near its limit, refused then taken restart
   task automatic tcase(input logic [7:0] c, input logic [7:0] t, input int idx, input int code,
                        input logic rl);
      int lim;
      lim = int'(TCYC[code]);
      wr(ADDR_CLOCK_ERROR_CONTROL, c);
      wr(ADDR_CLOCK_ERROR_TIMEOUT, t);
      run[idx] = 0;
      repeat (lim - 3) tick();
      chk("flag early", 8'(clock_error_flag), 8'h00);
      repeat (8) tick();
      chk("flag", 8'(clock_error_flag), 8'h01);
      chk("shutdown", 8'(fault_shutdown), 8'h01);
      run[idx] = 1;
      power_up_req = 1;
      tick();
      power_up_req = 0;
      tick();
      chk("refused", 8'(fault_shutdown), 8'h01);
      clock_error_clear = 1;
      tick();
      clock_error_clear = 0;
      power_up_req = 1;
      tick();
      power_up_req = 0;
      chk("restart", 8'(fault_shutdown), 8'h00);
      chk("reload", 8'(dsp_reload_defaults), 8'(rl));
      repeat (8) tick();
   endtask : tcase
   // clocks stopped where no enabled detector watches them
   task automatic quiet(input logic [7:0] c, input logic [4:0] m);
      wr(ADDR_CLOCK_ERROR_CONTROL, c);
      wr(ADDR_CLOCK_ERROR_TIMEOUT, 8'h00);
      run = m;
      repeat (60) tick();
      chk("no fault", 8'(clock_error_flag), 8'h00);
      run = 5'h1F;
      repeat (8) tick();
   endtask : quiet
   task automatic tally_and_finish();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      #1 reset_n = 1;
      regs_case();
      quiet(8'h00, 5'h00);
      quiet(8'h0D, 5'h00);
      quiet(8'h03, 5'h05);
      tcase(8'h03, 8'h07, 0, 0, 0);
      tcase(8'h93, 8'h3F, 1, 7, 1);
      tcase(8'h03, 8'h38, 2, 0, 0);
      tcase(8'h87, 8'h3B, 3, 3, 1);
      tcase(8'h0B, 8'h3D, 4, 5, 0);
      wr(ADDR_CLOCK_ERROR_CONTROL, 8'h80);
      other_fault = 1;
      tick();
      other_fault = 0;
      power_up_req = 1;
      tick();
      power_up_req = 0;
      chk("fault reload", 8'(dsp_reload_defaults), 8'h01);
      tally_and_finish();
   end
endmodule : tb
